// file: design/ssp_port.sv
// Serial programming port with register array and readback
`timescale 1ns/100ps
`include "ssp_consts.svh"
module ssp_port import ssp_pkg::*; (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	// Serial link pins
	input  wire logic                      serial_clock,
	input  wire logic                      serial_data_in,
	input  wire logic                      chip_select_n,
	// Output pin and its sources
	input  wire logic                      output_pin_function_select,
	input  wire logic                      lock_indicator,
	output logic                           multiplexed_output_pin,
	output logic                           multiplexed_output_pin_oe,
	// Register write strobe to the core
	output ssp_wr_t                        reg_wr
);
	logic [2:0]                  sck_sync_ff;
	logic [1:0]                  din_sync_ff;
	logic [1:0]                  csn_sync_ff;
	logic [1:0]                  sel_sync_ff;
	logic [1:0]                  lock_sync_ff;
	logic                        sck, sck_q, din, csn, sck_rise, sck_fall;
	logic                        rd_msb;
	ssp_state_t                  state_ff, nxt_state;
	logic [`SSP_CNT_W-1:0]       cnt_ff, nxt_cnt;
	logic [`SSP_FRAME_BITS-1:0]  shift_ff, nxt_shift;
	logic                        rd_ff, nxt_rd;
	logic [`SSP_DATA_W-1:0]      rdsh_ff, nxt_rdsh;
	logic                        sdo_ff, nxt_sdo;
	logic                        pin_ff, nxt_pin;
	ssp_wr_t                     wr_ff, nxt_wr;
	logic [`SSP_DATA_W-1:0]      regs [`SSP_NUM_REGS];

	// Counter step for one serial bit
	function automatic logic [`SSP_CNT_W-1:0] ssp_inc(input logic [`SSP_CNT_W-1:0] c);
		return c + 5'h1;
	endfunction

	// Shift register with a new bit at the bottom
	function automatic logic [`SSP_FRAME_BITS-1:0] ssp_shift_in(input logic [`SSP_FRAME_BITS-1:0] s, input logic b);
		return {s[`SSP_FRAME_BITS-2:0], b};
	endfunction

	// Frame still has bits to take
	function automatic logic ssp_frame_open(input logic [`SSP_CNT_W-1:0] c);
		return c != 5'(`SSP_FRAME_BITS);
	endfunction

	// Two-flop input synchronisers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sck_sync_ff  <= 3'h0;
			din_sync_ff  <= 2'h0;
			csn_sync_ff  <= 2'h3;
			sel_sync_ff  <= 2'h0;
			lock_sync_ff <= 2'h0;
		end else begin
			sck_sync_ff  <= {sck_sync_ff[1:0], serial_clock};
			din_sync_ff  <= {din_sync_ff[0], serial_data_in};
			csn_sync_ff  <= {csn_sync_ff[0], chip_select_n};
			sel_sync_ff  <= {sel_sync_ff[0], output_pin_function_select};
			lock_sync_ff <= {lock_sync_ff[0], lock_indicator};
		end
	end

	assign sck      = sck_sync_ff[1];
	assign sck_q    = sck_sync_ff[2];
	assign din      = din_sync_ff[1];
	assign rd_msb   = rdsh_ff[`SSP_DATA_W-1];
	assign csn      = csn_sync_ff[1];
	assign sck_rise = sck & ~sck_q;
	assign sck_fall = ~sck & sck_q;

	// Frame sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_shift = shift_ff;
		nxt_rd    = rd_ff;
		nxt_rdsh  = rdsh_ff;
		nxt_sdo   = sdo_ff;
		nxt_wr    = '0;
		if (csn) begin
			nxt_state = SSP_IDLE;
			nxt_cnt   = '0;
			nxt_sdo   = 1'b0;
			nxt_rd    = 1'b0;
		end else begin
			case (state_ff)
				SSP_IDLE: begin
					nxt_state = SSP_HDR;
					nxt_cnt   = '0;
					nxt_sdo   = 1'b0;
				end
				SSP_HDR: begin
					if (sck_rise) begin
						nxt_shift = ssp_shift_in(shift_ff, din);
						nxt_cnt   = ssp_inc(cnt_ff);
						if (cnt_ff == 5'h0)
							nxt_rd = din;
						if (cnt_ff == 5'(`SSP_HDR_BITS - 1)) begin
							nxt_state = SSP_DATA;
							nxt_rdsh  = regs[{shift_ff[`SSP_ADDR_W-2:0], din}];
						end
					end
					nxt_sdo = 1'b0;
				end
				SSP_DATA: begin
					if (rd_ff) begin
						if (sck_fall) begin
							nxt_sdo  = rd_msb;
							nxt_rdsh = {rdsh_ff[`SSP_DATA_W-2:0], 1'b0};
						end
						if (sck_rise && ssp_frame_open(cnt_ff))
							nxt_cnt = ssp_inc(cnt_ff);
					end else if (sck_rise && ssp_frame_open(cnt_ff)) begin
						nxt_shift = ssp_shift_in(shift_ff, din);
						nxt_cnt   = ssp_inc(cnt_ff);
						if (cnt_ff == 5'(`SSP_FRAME_BITS - 1)) begin
							nxt_wr.wr_en = 1'b1;
							nxt_wr.addr  = shift_ff[`SSP_FRAME_BITS-3:`SSP_DATA_W-1];
							nxt_wr.data  = {shift_ff[`SSP_DATA_W-2:0], din};
						end
					end
				end
				default: nxt_state = SSP_IDLE;
			endcase
		end
		nxt_pin = sel_sync_ff[1] ? lock_sync_ff[1] : nxt_sdo;
	end

	// Frame state registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_ff <= SSP_IDLE;
			cnt_ff   <= '0;
			shift_ff <= '0;
			rd_ff    <= 1'b0;
			rdsh_ff  <= '0;
			sdo_ff   <= 1'b0;
			pin_ff   <= 1'b0;
			wr_ff    <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			shift_ff <= nxt_shift;
			rd_ff    <= nxt_rd;
			rdsh_ff  <= nxt_rdsh;
			sdo_ff   <= nxt_sdo;
			pin_ff   <= nxt_pin;
			wr_ff    <= nxt_wr;
		end
	end

	// Register array, written only by completed write frames
	always_ff @(posedge ref_clk) begin
		if (wr_ff.wr_en)
			regs[wr_ff.addr] <= wr_ff.data;
	end

	// Output pin and write strobe
	assign multiplexed_output_pin    = pin_ff;
	assign multiplexed_output_pin_oe = 1'b1;
	assign reg_wr                    = wr_ff;

	// Protocol checks
	a_hdr_low: assert property (@(posedge ref_clk) disable iff (rst)
		(state_ff == SSP_HDR && !sel_sync_ff[1]) |=> !multiplexed_output_pin)
		else $error("Output pin not low during header");
	a_cs_ignore: assert property (@(posedge ref_clk) disable iff (rst)
		csn |=> (state_ff == SSP_IDLE && !wr_ff.wr_en))
		else $error("Activity while select high");
	a_pin_driven: assert property (@(posedge ref_clk) disable iff (rst)
		multiplexed_output_pin_oe)
		else $error("Output pin released");
	a_lock_mode: assert property (@(posedge ref_clk) disable iff (rst)
		sel_sync_ff[1] |=> multiplexed_output_pin == $past(lock_sync_ff[1]))
		else $error("Lock indicator not on pin");
	a_shift_rise: assert property (@(posedge ref_clk) disable iff (rst)
		(state_ff == SSP_HDR && !csn && sck_rise) |=> shift_ff[0] == $past(din))
		else $error("Data not captured on rising edge");
	a_read_nowr: assert property (@(posedge ref_clk) disable iff (rst)
		rd_ff |=> !wr_ff.wr_en)
		else $error("Write during readback");
	a_sdo_fall: assert property (@(posedge ref_clk) disable iff (rst)
		(state_ff == SSP_DATA && rd_ff && !csn && !sck_fall) |=> sdo_ff == $past(sdo_ff))
		else $error("Readback bit changed off falling edge");
	a_wr_width: assert property (@(posedge ref_clk) disable iff (rst)
		nxt_wr.wr_en |-> (cnt_ff == 5'(`SSP_FRAME_BITS - 1) && !rd_ff))
		else $error("Write strobe at wrong bit");
	a_read_hold: assert property (@(posedge ref_clk) disable iff (rst)
		(state_ff == SSP_DATA && rd_ff && !csn) |=> $stable(shift_ff))
		else $error("Shift register changed during readback");
	a_sdo_msb: assert property (@(posedge ref_clk) disable iff (rst)
		(state_ff == SSP_DATA && rd_ff && !csn && sck_fall) |=> sdo_ff == $past(rd_msb))
		else $error("Readback bit not taken from register msb");
	a_idle_low: assert property (@(posedge ref_clk) disable iff (rst)
		(csn && !sel_sync_ff[1]) |=> !multiplexed_output_pin)
		else $error("Output pin not low between frames");
	a_cnt_bound: assert property (@(posedge ref_clk) disable iff (rst)
		cnt_ff <= 5'(`SSP_FRAME_BITS))
		else $error("Bit counter past frame length");
	a_hdr_len: assert property (@(posedge ref_clk) disable iff (rst)
		state_ff == SSP_HDR |-> cnt_ff < 5'(`SSP_HDR_BITS))
		else $error("Header longer than its bit count");
	a_data_len: assert property (@(posedge ref_clk) disable iff (rst)
		state_ff == SSP_DATA |-> cnt_ff >= 5'(`SSP_HDR_BITS))
		else $error("Data phase entered before header done");
	a_rw_capture: assert property (@(posedge ref_clk) disable iff (rst)
		(state_ff == SSP_HDR && cnt_ff == 5'h0 && sck_rise && !csn) |=> rd_ff == $past(din))
		else $error("Read/write bit not taken from first bit");
	a_wr_pulse: assert property (@(posedge ref_clk) disable iff (rst)
		wr_ff.wr_en |=> !wr_ff.wr_en)
		else $error("Write strobe longer than one cycle");

	// Scenario covers
	c_write: cover property (@(posedge ref_clk) disable iff (rst) wr_ff.wr_en);
	c_read: cover property (@(posedge ref_clk) disable iff (rst) rd_ff && state_ff == SSP_DATA && sck_fall);
	c_abort: cover property (@(posedge ref_clk) disable iff (rst) state_ff == SSP_HDR && csn);
	c_lock: cover property (@(posedge ref_clk) disable iff (rst) sel_sync_ff[1] && lock_sync_ff[1]);
	c_ignore: cover property (@(posedge ref_clk) disable iff (rst) csn && sck_rise);
endmodule

// file: design/ssp_consts.svh
// Constants for the synthesizer serial programming port
// Functional notes
// - Device captures data input on each serial clock rising edge of the header and of write data bits.
// - Device shifts only while select is low; clock pulses otherwise ignored.
// - Readback output held low during read/write and address bits.
// - Readback data bit changes shortly after each serial clock falling edge.
// - Data input bits during readback data phase never alter registers.
// - Output pin carries readback only when function select is zero, else lock.
// - Output pin is always driven, never high impedance.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_ADDR_W     7
`define SSP_DATA_W     16
`define SSP_NUM_REGS   128
`define SSP_HDR_BITS   8
`define SSP_FRAME_BITS 24
`define SSP_CNT_W      5
`define SSP_REG_RESET  16'h0000
`endif

// file: design/ssp_pkg.sv
// Types for the synthesizer serial programming port
package ssp_pkg;
	typedef enum logic [2:0] {
		SSP_IDLE = 3'b001,
		SSP_HDR  = 3'b010,
		SSP_DATA = 3'b100
	} ssp_state_t;
	typedef struct packed {
		logic        wr_en;
		logic [6:0]  addr;
		logic [15:0] data;
	} ssp_wr_t;
endpackage

// file: sim/ssp_host.sv
// Host serial controller model
`timescale 1ns/100ps
module ssp_host (
	// Clock and readback pin
	input  wire logic ref_clk,
	input  wire logic pin,
	// Serial link pins
	output logic      sck,
	output logic      din,
	output logic      csn
);
	initial begin
		sck = 1'b0;
		din = 1'b0;
		csn = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Clock pulses with select high
	task automatic clk_only();
		repeat (4) begin
			wt(20);
			sck = 1'b1;
			wt(20);
			sck = 1'b0;
		end
	endtask
	// Frame of n bits msb first, pin sampled per bit
	task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
		rx = 24'h00_0000;
		csn = 1'b0;
		wt(20);
		for (int i = 23; i > 23 - n; i--) begin
			din = tx[i];
			wt(20);
			sck = 1'b1;
			rx[i] = pin;
			wt(20);
			sck = 1'b0;
		end
		wt(5);
		csn = 1'b1;
		din = ~din;
		wt(10);
	endtask
endmodule

// file: sim/test_ssp_port.sv
// Bench for the serial programming port
`timescale 1ns/100ps
`define CHK(nm, ex, sn) begin \
	compares++; \
	if ((ex) !== (sn)) begin \
		bad_count++; \
		$display("[ERR] %s exp %h got %h", nm, ex, sn); \
	end \
end
module test_ssp_port;
	import ssp_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        sck;
	logic        din;
	logic        csn;
	logic        fsel = 1'b0;
	logic        lock = 1'b0;
	logic        pin;
	logic        oe;
	ssp_wr_t     reg_wr;
	ssp_wr_t     last_wr;
	int          wr_n = 0;
	int          bad_count = 0;
	int          compares = 0;
	logic [23:0] rx;
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (reg_wr.wr_en === 1'b1) begin
			last_wr <= reg_wr;
			wr_n <= wr_n + 1;
		end
	end
	ssp_host host (.ref_clk(ref_clk), .pin(pin), .sck(sck), .din(din), .csn(csn));
	ssp_port uut (.ref_clk(ref_clk), .rst(rst), .serial_clock(sck), .serial_data_in(din),
		.chip_select_n(csn), .output_pin_function_select(fsel), .lock_indicator(lock),
		.multiplexed_output_pin(pin), .multiplexed_output_pin_oe(oe), .reg_wr(reg_wr));
	task automatic summarize();
		if (bad_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Write, then read back with ones on data input
	task automatic t_wr_rd(input logic [6:0] a, input logic [15:0] d);
		int n;
		n = wr_n;
		host.xfer({1'b0, a, d}, 24, rx);
		`CHK("wr_n", n + 1, wr_n)
		`CHK("addr", a, last_wr.addr)
		`CHK("data", d, last_wr.data)
		host.xfer({1'b1, a, 16'hFFFF}, 24, rx);
		`CHK("hdr", 8'h00, rx[23:16])
		`CHK("rd", d, rx[15:0])
		`CHK("rd_wr_n", n + 1, wr_n)
	endtask
	// Ignored clocks and two cut frames write nothing
	task automatic t_ignore();
		int n;
		n = wr_n;
		host.clk_only();
		host.xfer({1'b0, 7'h22, 16'h5555}, 4, rx);
		host.xfer({1'b0, 7'h22, 16'h5555}, 10, rx);
		`CHK("ign_n", n, wr_n)
		t_wr_rd(7'h11, 16'h1234);
	endtask
	// Lock mode on the pin, pin always driven
	task automatic t_lock();
		fsel = 1'b1;
		lock = 1'b1;
		host.wt(10);
		`CHK("lock1", 1'b1, pin)
		lock = 1'b0;
		host.wt(10);
		`CHK("lock0", 1'b0, pin)
		`CHK("oe", 1'b1, oe)
		fsel = 1'b0;
		host.wt(10);
	endtask
	initial begin
		#100000;
		bad_count++;
		summarize();
	end
	initial begin
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		host.wt(5);
		t_wr_rd(7'h05, 16'hA5C3);
		t_wr_rd(7'h7F, 16'h8001);
		t_ignore();
		t_lock();
		summarize();
	end
endmodule
